// File: core/srw_pkg.sv
/*
 * Shared constants of the supervisor reset and watchdog block: clock rate,
 * time base, hold period options, watchdog periods and input filter time.
 * Assumes a 20 MHz core clock; every period is derived from it here.
 */
package srw_pkg;

  // ----------------------------------------------------------------------
  // Clock and time base
  // ----------------------------------------------------------------------
  localparam int unsigned SRW_CLK_PERIOD_NS = 50;
  localparam int unsigned SRW_TICK_US       = 100;
  localparam int unsigned SRW_TICK_CYCLES   =
    SRW_TICK_US * 1000 / SRW_CLK_PERIOD_NS;

  // ----------------------------------------------------------------------
  // Counter widths
  // ----------------------------------------------------------------------
  localparam int unsigned SRW_PRE_W = 11;
  localparam int unsigned SRW_CNT_W = 19;
  localparam int unsigned SRW_DEB_W = 5;

  // ----------------------------------------------------------------------
  // Hold period options, least time of each, in microseconds
  // ----------------------------------------------------------------------
  localparam int unsigned SRW_HOLD_OPTIONS = 6;
  localparam int unsigned SRW_HOLD_MIN_US [SRW_HOLD_OPTIONS] =
    '{1100, 8800, 140000, 280000, 560000, 1120000};
  localparam int unsigned SRW_HOLD_SEL_STD = 2;

  // Least times round up to whole ticks
  function automatic int unsigned srw_hold_ticks(input int unsigned sel);
    int unsigned us;
    us = SRW_HOLD_MIN_US[sel];
    return (us + SRW_TICK_US - 1) / SRW_TICK_US;
  endfunction

  // ----------------------------------------------------------------------
  // Watchdog periods, least time, in milliseconds
  // ----------------------------------------------------------------------
  localparam int unsigned SRW_BOOT_TIMEOUT_MS = 35000;
  localparam int unsigned SRW_RUN_TIMEOUT_MS  = 1120;
  localparam int unsigned SRW_BOOT_TICKS      =
    (SRW_BOOT_TIMEOUT_MS * 1000 + SRW_TICK_US - 1) / SRW_TICK_US;
  localparam int unsigned SRW_RUN_TICKS       =
    (SRW_RUN_TIMEOUT_MS * 1000 + SRW_TICK_US - 1) / SRW_TICK_US;

  // ----------------------------------------------------------------------
  // Push-button filter
  // ----------------------------------------------------------------------
  localparam int unsigned SRW_DEB_NS     = 1000;
  localparam int unsigned SRW_DEB_CYCLES =
    (SRW_DEB_NS + SRW_CLK_PERIOD_NS - 1) / SRW_CLK_PERIOD_NS;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic SRW_SYS_RST_N_RST = 1'b0;
  localparam logic SRW_ALARM_N_RST   = 1'b1;
  localparam logic SRW_PB_N_RST      = 1'b1;

  typedef enum logic [0:0] {
    SRW_WD_BOOT = 1'b0,
    SRW_WD_RUN  = 1'b1
  } srw_wd_mode_t;

endpackage

// File: core/srw_supervisor.sv
/*
 * Supervisor reset and watchdog control logic.
 * Assumes the undervoltage flags, push-button and heartbeat inputs are
 * asynchronous to ref_clk_i, and the clock runs free from power-up.
 */
// Behaviour
// [RQ1] Reset output is low while an enabled flag is high or the push-button is low.
// [RQ2] Reset stays low for one full hold period after every cause clears.
// [RQ3] The hold period is one of six build-time options, 140 ms by default.
// [RQ4] A new undervoltage during the hold restarts the hold timer from zero.
// [RQ5] One, two or three supply monitors are enabled by parameter.
// [RQ6] Push-button low asserts reset, clears the watchdog, holds alarm high.
// [RQ7] The push-button is filtered so a bouncing switch gives one reset.
// [RQ8] Either heartbeat edge services; no edge in the period lowers alarm.
// [RQ9] After each reset the watchdog uses a long first period, 35 s least.
// [RQ10] The 1.12 s period starts at first heartbeat edge or first expiry.
// [RQ11] Alarm looped to push-button: expiry resets, clears count, lifts alarm.
// [RQ12] After such a reset the long period restarts when the hold ends.
// [RQ13] Processor software toggles the heartbeat at separate program points.
// [RQ14] The watchdog count clears while reset is low and on every edge.
// [RQ15] Alarm is low during undervoltage and releases at once when clear.
// [RQ16] Periods come from a prescaled time base; inputs are synchronised.
`timescale 1ns/1ps
`default_nettype none

module srw_supervisor #(
  parameter int unsigned NUM_MONITORS = 3,
  parameter int unsigned TICK_CYCLES  = srw_pkg::SRW_TICK_CYCLES,
  parameter int unsigned HOLD_TICKS   =
    srw_pkg::srw_hold_ticks(srw_pkg::SRW_HOLD_SEL_STD),
  parameter int unsigned BOOT_TICKS   = srw_pkg::SRW_BOOT_TICKS,
  parameter int unsigned RUN_TICKS    = srw_pkg::SRW_RUN_TICKS
) (
  input  wire logic ref_clk_i,
  input  wire logic rst_i,
  input  wire logic primary_supply_low_i,
  input  wire logic secondary_supply_low_i,
  input  wire logic aux_monitor_in_low_i,
  input  wire logic push_button_reset_n_i,
  input  wire logic heartbeat_in_i,
  output var  logic system_reset_n_o,
  output var  logic timeout_alarm_n_o
);
  import srw_pkg::*;

  // ----------------------------------------------------------------------
  // Limits
  // ----------------------------------------------------------------------
  localparam logic [SRW_PRE_W-1:0] TICK_LIM = SRW_PRE_W'(TICK_CYCLES - 1);
  localparam logic [SRW_CNT_W-1:0] HOLD_LIM = SRW_CNT_W'(HOLD_TICKS);
  localparam logic [SRW_CNT_W-1:0] BOOT_LIM = SRW_CNT_W'(BOOT_TICKS);
  localparam logic [SRW_CNT_W-1:0] RUN_LIM  = SRW_CNT_W'(RUN_TICKS);
  localparam logic [SRW_DEB_W-1:0] DEB_LIM  = SRW_DEB_W'(SRW_DEB_CYCLES - 1);
  // Mask keeps a disabled monitor away from the reset logic
  localparam logic [2:0]           MON_MASK =
    (NUM_MONITORS >= 3) ? 3'h7 : ((NUM_MONITORS == 2) ? 3'h3 : 3'h1);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [2:0]           uv_s1;
    logic [2:0]           uv_s2;
    logic                 pb_s1;
    logic                 pb_s2;
    logic                 hb_s1;
    logic                 hb_s2;
    logic                 hb_prev;
    logic                 pb_filt;
    logic [SRW_DEB_W-1:0] deb_cnt;
    logic [SRW_PRE_W-1:0] pre_cnt;
    logic                 tick;
    logic [SRW_CNT_W-1:0] hold_cnt;
    logic                 sys_rst_n;
    srw_wd_mode_t         wd_mode;
    logic [SRW_CNT_W-1:0] wd_cnt;
    logic                 wd_expired;
    logic                 alarm_n;
  } srw_state_t;

  // Idle levels: button released, no fault, reset asserted
  localparam srw_state_t STATE_RST = '{
    uv_s1:      3'h0,
    uv_s2:      3'h0,
    pb_s1:      SRW_PB_N_RST,
    pb_s2:      SRW_PB_N_RST,
    hb_s1:      1'b0,
    hb_s2:      1'b0,
    hb_prev:    1'b0,
    pb_filt:    SRW_PB_N_RST,
    deb_cnt:    '0,
    pre_cnt:    '0,
    tick:       1'b0,
    hold_cnt:   '0,
    sys_rst_n:  SRW_SYS_RST_N_RST,
    wd_mode:    SRW_WD_BOOT,
    wd_cnt:     '0,
    wd_expired: 1'b0,
    alarm_n:    SRW_ALARM_N_RST
  };

  srw_state_t           s_reg;
  srw_state_t           s_next;
  logic                 uv_now;
  logic                 pb_low;
  logic                 fault_now;
  logic                 hb_edge;
  logic [SRW_CNT_W-1:0] wd_lim;

  // Decoded causes; only synchronised levels are read here
  assign uv_now    = |(s_reg.uv_s2 & MON_MASK); // RQ5
  assign pb_low    = !s_reg.pb_filt;
  assign fault_now = uv_now || pb_low;
  assign hb_edge   = s_reg.hb_s2 ^ s_reg.hb_prev; // RQ8
  assign wd_lim    = (s_reg.wd_mode == SRW_WD_BOOT) ? BOOT_LIM : RUN_LIM;

  // ----------------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------------
  always_comb begin
    s_next = s_reg;

    // Two-flop synchronisers, second stage is the only reader of the first
    s_next.uv_s1   = {aux_monitor_in_low_i, secondary_supply_low_i,
                      primary_supply_low_i}; // RQ16
    s_next.uv_s2   = s_reg.uv_s1;
    s_next.pb_s1   = push_button_reset_n_i;
    s_next.pb_s2   = s_reg.pb_s1;
    s_next.hb_s1   = heartbeat_in_i;
    s_next.hb_s2   = s_reg.hb_s1;
    s_next.hb_prev = s_reg.hb_s2;

    // Filter: a new level must hold a full window, so bounce is absorbed
    if (s_reg.pb_s2 != s_reg.pb_filt) begin
      if (s_reg.deb_cnt == DEB_LIM) begin
        s_next.pb_filt = s_reg.pb_s2; // RQ7
        s_next.deb_cnt = '0;
      end else begin
        s_next.deb_cnt = s_reg.deb_cnt + 1'b1;
      end
    end else begin
      s_next.deb_cnt = '0;
    end

    // Shared prescaler; trades period resolution for small counters
    s_next.tick    = (s_reg.pre_cnt == TICK_LIM); // RQ16
    s_next.pre_cnt = s_next.tick ? '0 : s_reg.pre_cnt + 1'b1;

    // Reset hold; ticks are counted one past the limit so a partial first
    // tick never shortens the least hold time
    if (fault_now) begin
      s_next.sys_rst_n = 1'b0; // RQ1
      s_next.hold_cnt  = '0; // RQ4
    end else if (!s_reg.sys_rst_n && s_reg.tick) begin
      if (s_reg.hold_cnt == HOLD_LIM) begin
        s_next.sys_rst_n = 1'b1; // RQ2 RQ3
        s_next.hold_cnt  = '0;
      end else begin
        s_next.hold_cnt = s_reg.hold_cnt + 1'b1;
      end
    end

    // Watchdog
    // Reset and faults win, so an edge seen in reset keeps the long period
    if (!s_reg.sys_rst_n || fault_now) begin
      s_next.wd_cnt     = '0; // RQ14 RQ6 RQ11
      s_next.wd_mode    = SRW_WD_BOOT; // RQ9 RQ12
      s_next.wd_expired = 1'b0;
    end else if (hb_edge) begin
      s_next.wd_cnt     = '0; // RQ14
      s_next.wd_mode    = SRW_WD_RUN; // RQ10
      s_next.wd_expired = 1'b0;
    end else if (s_reg.tick) begin
      if (s_reg.wd_cnt == wd_lim) begin
        s_next.wd_cnt     = '0;
        s_next.wd_mode    = SRW_WD_RUN; // RQ10
        s_next.wd_expired = 1'b1; // RQ8
      end else begin
        s_next.wd_cnt = s_reg.wd_cnt + 1'b1;
      end
    end

    // Alarm: push-button forces high, undervoltage forces low, no hold
    if (pb_low) begin
      s_next.alarm_n = 1'b1; // RQ6 RQ11
    end else if (uv_now) begin
      s_next.alarm_n = 1'b0; // RQ15
    end else begin
      s_next.alarm_n = !s_next.wd_expired; // RQ8 RQ15
    end
  end

  // Synchronous reset; a full hold period follows it, as at power-up
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      s_reg <= STATE_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  // Both outputs come straight from flip-flops, so no glitch reaches a pin
  assign system_reset_n_o  = s_reg.sys_rst_n;
  assign timeout_alarm_n_o = s_reg.alarm_n;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  // Named steps; hold_done_s serves one check, wd_expiry_s two
  sequence hold_done_s;
    !fault_now && !s_reg.sys_rst_n && s_reg.tick
      && (s_reg.hold_cnt == HOLD_LIM);
  endsequence

  sequence wd_expiry_s;
    s_reg.sys_rst_n && !fault_now && !hb_edge && s_reg.tick
      && (s_reg.wd_cnt == wd_lim);
  endsequence

  chk_fault_reset_low: assert property ( // RQ1
    fault_now |=> !system_reset_n_o)
    else $error("reset not asserted on fault");

  chk_hold_release: assert property ( // RQ2
    $rose(system_reset_n_o) |-> $past(s_reg.hold_cnt) == HOLD_LIM)
    else $error("reset released before hold period");

  chk_hold_length: assert property ( // RQ3
    hold_done_s |=> system_reset_n_o && s_reg.hold_cnt == '0)
    else $error("reset not released at end of hold");

  chk_hold_restart: assert property ( // RQ4
    (uv_now && !system_reset_n_o) |=> s_reg.hold_cnt == '0)
    else $error("hold timer not restarted");

  chk_monitor_mask: assert property ( // RQ5
    (|(s_reg.uv_s2 & ~MON_MASK) && !pb_low && system_reset_n_o
      && !(|(s_reg.uv_s2 & MON_MASK))) |=> system_reset_n_o)
    else $error("disabled monitor caused reset");

  chk_pb_alarm_high: assert property ( // RQ6
    pb_low |=> timeout_alarm_n_o && s_reg.wd_cnt == '0)
    else $error("push-button did not clear watchdog");

  chk_pb_filter: assert property ( // RQ7
    $changed(s_reg.pb_filt) |-> $past(s_reg.deb_cnt) == DEB_LIM)
    else $error("push-button level taken unfiltered");

  chk_expiry_alarm: assert property ( // RQ8
    wd_expiry_s |=> !timeout_alarm_n_o)
    else $error("alarm not asserted on expiry");

  chk_boot_mode: assert property ( // RQ9
    !system_reset_n_o |=> s_reg.wd_mode == SRW_WD_BOOT)
    else $error("watchdog not in long period after reset");

  chk_edge_run: assert property ( // RQ10
    (hb_edge && system_reset_n_o && !fault_now)
      |=> s_reg.wd_mode == SRW_WD_RUN && s_reg.wd_cnt == '0)
    else $error("heartbeat edge did not service watchdog");

  chk_loop_reset: assert property ( // RQ11
    (!timeout_alarm_n_o && pb_low) |=> !system_reset_n_o
      ##0 timeout_alarm_n_o)
    else $error("looped alarm did not reset");

  chk_uv_alarm: assert property ( // RQ15
    (uv_now && !pb_low) |=> !timeout_alarm_n_o)
    else $error("alarm not low during undervoltage");

  chk_tick_period: assert property ( // RQ16
    s_reg.tick |=> !s_reg.tick)
    else $error("time base tick too long");

  chk_hold_on_tick: assert property ( // RQ2
    (!system_reset_n_o && !s_reg.tick) |=> !system_reset_n_o)
    else $error("reset released off a tick");

  chk_reset_clears_wd: assert property ( // RQ14
    !system_reset_n_o |=> s_reg.wd_cnt == '0)
    else $error("watchdog count not cleared in reset");

  chk_expiry_to_run: assert property ( // RQ10
    wd_expiry_s |=> s_reg.wd_mode == SRW_WD_RUN && s_reg.wd_cnt == '0)
    else $error("expiry did not enter short period");

  chk_release_boot: assert property ( // RQ12
    $rose(system_reset_n_o) |-> s_reg.wd_mode == SRW_WD_BOOT
      && s_reg.wd_cnt == '0)
    else $error("watchdog not restarted in long period");

  // Alarm release checks; the looped push-button path leans on these
  chk_alarm_release: assert property ( // RQ15
    ($fell(uv_now) && !pb_low) |=> timeout_alarm_n_o)
    else $error("alarm not released when supplies clear");

  chk_edge_lifts_alarm: assert property ( // RQ8
    (hb_edge && system_reset_n_o && !fault_now) |=> timeout_alarm_n_o)
    else $error("heartbeat edge did not lift alarm");

endmodule

`default_nettype wire

// File: tb/srw_cpu_model.sv
/*
 * Model of the supervised processor: heartbeat line and push-button node.
 * Assumes the bench asks for each heartbeat flip with a one-cycle request.
 */
`timescale 1ns/1ps
`default_nettype none
module srw_cpu_model (
  input  wire logic ref_clk_i,
  input  wire logic toggle_req_i,
  input  wire logic loop_en_i,
  input  wire logic button_n_i,
  input  wire logic alarm_n_i,
  output var  logic heartbeat_o,
  output var  logic push_button_n_o
);
  // ----------------------------------------------------------------------
  // Heartbeat
  // ----------------------------------------------------------------------
  // Level flips once per request, never a pulse, so a stuck loop shows
  logic hb_q = 1'b0;
  always @(posedge ref_clk_i) begin
    if (toggle_req_i) begin
      hb_q <= #5 ~hb_q;
    end
  end
  assign heartbeat_o = hb_q;
  // ----------------------------------------------------------------------
  // Button node
  // ----------------------------------------------------------------------
  // Strapped alarm pulls the node low like an open-drain wire
  assign push_button_n_o = loop_en_i ? (alarm_n_i & button_n_i) : button_n_i;
endmodule
`default_nettype wire

// File: tb/srw_supervisor_tb_top.sv
/*
 * Self-checking bench of the supervisor with short periods.
 * Assumes the processor model in srw_cpu_model and a 20 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none
module srw_supervisor_tb_top;
  import srw_pkg::*;
  // ----------------------------------------------------------------------
  // Setup
  // ----------------------------------------------------------------------
  localparam int TC = 2;
  localparam int HT = 3;
  localparam int BT = 20;
  localparam int RT = 5;
  localparam int DEB = SRW_DEB_CYCLES;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic [2:0] low = 3'h0;
  logic       btn_n = 1'b1;
  logic       tog = 1'b0;
  logic       loop_en = 1'b0;
  logic       hb;
  logic       pb_n;
  logic       sys_n;
  logic       alm_n;
  int         miscompares = 0;
  int         samples_checked = 0;
  int         cycles = 0;
  int         n;
  always #25 clk = ~clk;
  // Aux flag left disabled so a masked monitor is exercised
  srw_supervisor #(.NUM_MONITORS(2), .TICK_CYCLES(TC), .HOLD_TICKS(HT),
    .BOOT_TICKS(BT), .RUN_TICKS(RT)) dut_u (
    .ref_clk_i(clk), .rst_i(rst), .primary_supply_low_i(low[0]),
    .secondary_supply_low_i(low[1]), .aux_monitor_in_low_i(low[2]),
    .push_button_reset_n_i(pb_n), .heartbeat_in_i(hb),
    .system_reset_n_o(sys_n), .timeout_alarm_n_o(alm_n));
  srw_cpu_model cpu_u (.ref_clk_i(clk), .toggle_req_i(tog),
    .loop_en_i(loop_en), .button_n_i(btn_n), .alarm_n_i(alm_n),
    .heartbeat_o(hb), .push_button_n_o(pb_n));
  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  task automatic close_out();
    $display("compares %0d mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // Hang guard: whole run is well under a thousand cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      miscompares++;
      close_out();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic step(input int k);
    repeat (k) @(posedge clk);
    #5;
  endtask
  task automatic hb_edge();
    tog = 1'b1;
    step(1);
    tog = 1'b0;
  endtask
  // Cycles until reset (sel 0) or alarm (sel 1) reaches v, bounded
  task automatic wait_for(input bit sel, input logic v, input int lim,
                          output int k);
    k = 0;
    while (((sel ? alm_n : sys_n) !== v) && k < lim) begin
      step(1);
      k++;
    end
  endtask
  task automatic in_range(input int k, input int lo, input int hi);
    check(32'(k >= lo && k <= hi), 32'h1);
  endtask
  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic s_power_up();
    check(sys_n, 1'b0);
    check(alm_n, 1'b1);
    wait_for(0, 1'b1, 60, n);
    in_range(n, HT * TC, (HT + 1) * TC + 6);
  endtask
  task automatic s_watchdog();
    wait_for(1, 1'b0, 200, n);
    in_range(n, BT * TC, (BT + 1) * TC + 4);
    step(20);
    check(alm_n, 1'b0);
    hb_edge();
    wait_for(1, 1'b1, 6, n);
    check(alm_n, 1'b1);
    wait_for(1, 1'b0, 100, n);
    in_range(n, RT * TC - 2, (RT + 1) * TC + 4);
    for (int i = 0; i < 8; i++) begin
      hb_edge();
      step(7);
      check(alm_n, 1'b1);
    end
  endtask
  task automatic s_flags();
    for (int i = 0; i < 3; i++) begin
      low[i] = 1'b1;
      step(4);
      check(sys_n, 1'(i == 2));
      check(alm_n, 1'(i == 2));
      low[i] = 1'b0;
      step(4);
      check(alm_n, 1'b1);
      wait_for(0, 1'b1, 60, n);
      if (i < 2) begin
        in_range(n + 4, HT * TC, (HT + 1) * TC + 6);
      end else begin
        check(n, 0);
      end
    end
  endtask
  task automatic s_retrigger();
    low[0] = 1'b1;
    step(4);
    hb_edge();
    low[0] = 1'b0;
    step(4);
    low[1] = 1'b1;
    step(2);
    low[1] = 1'b0;
    wait_for(0, 1'b1, 60, n);
    in_range(n, HT * TC, (HT + 1) * TC + 6);
    wait_for(1, 1'b0, 200, n);
    in_range(n, BT * TC, (BT + 1) * TC + 4);
  endtask
  task automatic s_button();
    for (int i = 0; i < 3; i++) begin
      btn_n = 1'b0;
      step(5);
      btn_n = 1'b1;
      step(5);
      check(sys_n, 1'b1);
    end
    btn_n = 1'b0;
    step(DEB + 4);
    check(sys_n, 1'b0);
    check(alm_n, 1'b1);
    btn_n = 1'b1;
    wait_for(0, 1'b1, 100, n);
    in_range(n, HT * TC, (HT + 1) * TC + DEB + 6);
    wait_for(1, 1'b0, 200, n);
    in_range(n, BT * TC, (BT + 1) * TC + 4);
  endtask
  task automatic s_loopback();
    hb_edge();
    wait_for(1, 1'b1, 6, n);
    loop_en = 1'b1;
    wait_for(1, 1'b0, 100, n);
    wait_for(0, 1'b0, DEB + 6, n);
    check(sys_n, 1'b0);
    step(2);
    check(alm_n, 1'b1);
    wait_for(0, 1'b1, 100, n);
    wait_for(1, 1'b0, 200, n);
    in_range(n, BT * TC, (BT + 1) * TC + 4);
    loop_en = 1'b0;
  endtask
  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk);
    #5;
    rst = 1'b0;
    s_power_up();
    s_watchdog();
    s_flags();
    s_retrigger();
    s_button();
    s_loopback();
    close_out();
  end
endmodule
`default_nettype wire
